// >>> shared/pcu_regs.svh
// Register offsets, field positions and reset values of the pin control unit
`ifndef PCU_REGS_SVH
`define PCU_REGS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define PCU_ADDR_W        16
`define PCU_NPINS         8
`define PCU_PADDR_W       8

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PCU_USB_CS_OFF    8'h00
`define PCU_PIN_SEL_OFF   8'h04
`define PCU_RDY_ROUTE_OFF 8'h08
`define PCU_GPIO_OUT_OFF  8'h0c
`define PCU_GPIO_OE_OFF   8'h10
`define PCU_GPIO_IN_OFF   8'h14
`define PCU_DMA_ADDR_OFF  8'h18
`define PCU_DMA_LEN_OFF   8'h1c
`define PCU_DMA_CTRL_OFF  8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define PCU_USB_ATTACH_EN 2
`define PCU_USB_DISC      3
`define PCU_DMA_GO        0
`define PCU_DMA_DIR       1
`define PCU_DMA_BUSY      8
`define PCU_PIN_RDY_A     2
`define PCU_PIN_RDY_B     3
`define PCU_PIN_WR        6
`define PCU_PIN_RD        7

// ****************************************************************
// Reset values and the constant one
// ****************************************************************
`define PCU_USB_CS_RST    8'h00
`define PCU_PIN_RST       8'h00
`define PCU_RDY_RST       2'h0
`define PCU_ADDR_RST      16'h0000
`define PCU_ONE           16'h0001

`endif

// >>> shared/pcu_pkg.sv
// Types shared by the pin control unit
package pcu_pkg;

  typedef logic [15:0] pcu_addr_t;

  typedef enum logic [1:0] {
    PCU_DMA_IDLE,
    PCU_DMA_SETUP,
    PCU_DMA_STROBE
  } pcu_dma_state_e;

endpackage

// >>> rtl/pcu_pin_cell.sv
// One multiplexed pin: general-purpose or alternate function, registered
module pcu_pin_cell (
  input  wire logic clock,     // Core clock
  input  wire logic resetn,    // Synchronous reset, active low
  input  wire logic alt_sel,   // 1 selects the alternate function
  input  wire logic alt_out,   // Alternate function output level
  input  wire logic gpio_out,  // General-purpose output level
  input  wire logic gpio_oe,   // General-purpose output enable
  output logic      pad_out,   // Level driven onto the pin
  output logic      pad_oe     // High while the pin is driven
);

  // Alternate outputs always drive; general-purpose only when enabled
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
    end else if (alt_sel) begin
      pad_out <= alt_out;
      pad_oe  <= 1'b1;
    end else begin
      pad_out <= gpio_out;
      pad_oe  <= gpio_oe;
    end
  end

endmodule // pcu_pin_cell

// >>> rtl/pcu_pin_ctrl.sv
// Pin control unit: USB attach pin, external address bus, pin muxing
//
// The APB register port and the register offsets were decided locally.
`include "pcu_regs.svh"

// Overview of operation
// - Attach pin floats unless control bit two set
// - Attach pin drives inverse of control bit three
// - External address bus always driven, never floating
// - Internal RAM access address appears on bus while DMA idle
// - Strobed DMA places incrementing address per byte
// - Ready input four routable to none/either/both pins
// - Multiplexed pins reset to undriven general inputs
module pcu_pin_ctrl (
  input  wire logic                    clock,            // Core clock
  input  wire logic                    resetn,           // Sync reset, low
  input  wire logic [`PCU_PADDR_W-1:0] paddr,            // APB address
  input  wire logic                    psel,             // APB select
  input  wire logic                    penable,          // APB enable
  input  wire logic                    pwrite,           // APB write
  input  wire logic [31:0]             pwdata,           // APB write data
  output logic      [31:0]             prdata,           // APB read data
  output logic                         pready,           // APB ready
  output logic                         pslverr,          // APB error
  input  wire logic                    cpu_int_access,   // CPU RAM access
  input  wire logic [`PCU_ADDR_W-1:0]  cpu_int_addr,     // CPU RAM address
  input  wire logic [5:0]              alt_ctl_out,      // Alt outputs 0..5
  output logic      [`PCU_ADDR_W-1:0]  ext_addr,         // External address
  output logic                         usb_attach_out_n, // Attach pin level
  output logic                         usb_attach_oe,    // Attach pin drive
  input  wire logic [`PCU_NPINS-1:0]   pad_in,           // Mux pin inputs
  output logic      [`PCU_NPINS-1:0]   pad_out,          // Mux pin outputs
  output logic      [`PCU_NPINS-1:0]   pad_oe,           // Mux pin enables
  output logic                         ready_input_four, // Routed ready
  output logic                         dma_busy          // DMA in progress
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]                usb_control_status_reg;
  logic [`PCU_NPINS-1:0]     pin_sel;
  logic [1:0]                rdy_route;
  logic [`PCU_NPINS-1:0]     gpio_out;
  logic [`PCU_NPINS-1:0]     gpio_oe;
  pcu_pkg::pcu_addr_t        dma_start;
  pcu_pkg::pcu_addr_t        dma_len;
  logic                      dma_dir;
  logic [`PCU_NPINS-1:0]     pad_meta;
  logic [`PCU_NPINS-1:0]     pad_sync;
  pcu_pkg::pcu_dma_state_e   dma_state;
  pcu_pkg::pcu_addr_t        dma_cur;
  pcu_pkg::pcu_addr_t        dma_left;
  logic                      strobe_wr_n;
  logic                      strobe_rd_n;
  logic                      access;
  logic                      wr_en;
  logic                      dma_go;
  logic                      next_pslverr;
  logic [31:0]               next_prdata;
  logic [`PCU_NPINS-1:0]     alt_out;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // One wait state: ready rises in the second access cycle
  assign access = psel && penable && !pready;
  assign wr_en  = access && pwrite;
  assign dma_go = wr_en && (paddr == `PCU_DMA_CTRL_OFF)
                  && pwdata[`PCU_DMA_GO];

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (paddr)
      `PCU_USB_CS_OFF:    next_prdata[7:0] = usb_control_status_reg;
      `PCU_PIN_SEL_OFF:   next_prdata[7:0] = pin_sel;
      `PCU_RDY_ROUTE_OFF: next_prdata[1:0] = rdy_route;
      `PCU_GPIO_OUT_OFF:  next_prdata[7:0] = gpio_out;
      `PCU_GPIO_OE_OFF:   next_prdata[7:0] = gpio_oe;
      `PCU_GPIO_IN_OFF:   next_prdata[7:0] = pad_sync;
      `PCU_DMA_ADDR_OFF:  next_prdata[15:0] = dma_cur;
      `PCU_DMA_LEN_OFF:   next_prdata[15:0] = dma_left;
      `PCU_DMA_CTRL_OFF: begin
        next_prdata[`PCU_DMA_DIR]  = dma_dir;
        next_prdata[`PCU_DMA_BUSY] = dma_busy;
      end
      default:            next_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access && next_pslverr;
      prdata  <= (access && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      usb_control_status_reg <= `PCU_USB_CS_RST;
      pin_sel   <= `PCU_PIN_RST;
      rdy_route <= `PCU_RDY_RST;
      gpio_out  <= `PCU_PIN_RST;
      gpio_oe   <= `PCU_PIN_RST;
      dma_start <= `PCU_ADDR_RST;
      dma_len   <= `PCU_ADDR_RST;
      dma_dir   <= 1'b0;
    end else if (wr_en) begin
      unique case (paddr)
        `PCU_USB_CS_OFF:    usb_control_status_reg <= pwdata[7:0];
        `PCU_PIN_SEL_OFF:   pin_sel   <= pwdata[7:0];
        `PCU_RDY_ROUTE_OFF: rdy_route <= pwdata[1:0];
        `PCU_GPIO_OUT_OFF:  gpio_out  <= pwdata[7:0];
        `PCU_GPIO_OE_OFF:   gpio_oe   <= pwdata[7:0];
        `PCU_DMA_ADDR_OFF:  dma_start <= pwdata[15:0];
        `PCU_DMA_LEN_OFF:   dma_len   <= pwdata[15:0];
        `PCU_DMA_CTRL_OFF:  dma_dir   <= pwdata[`PCU_DMA_DIR];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // USB attach pin
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      usb_attach_oe    <= 1'b0;
      usb_attach_out_n <= 1'b1;
    end else begin
      usb_attach_oe    <= usb_control_status_reg[`PCU_USB_ATTACH_EN];
      usb_attach_out_n <= ~usb_control_status_reg[`PCU_USB_DISC];
    end
  end

  // ****************************************************************
  // Strobed DMA engine
  // ****************************************************************
  // A start with zero length is ignored rather than wrapping the count
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dma_state   <= pcu_pkg::PCU_DMA_IDLE;
      dma_cur     <= `PCU_ADDR_RST;
      dma_left    <= `PCU_ADDR_RST;
      strobe_wr_n <= 1'b1;
      strobe_rd_n <= 1'b1;
    end else begin
      unique case (dma_state)
        pcu_pkg::PCU_DMA_IDLE: begin
          if (dma_go && dma_len != `PCU_ADDR_RST) begin
            dma_cur   <= dma_start;
            dma_left  <= dma_len;
            dma_state <= pcu_pkg::PCU_DMA_SETUP;
          end
        end
        pcu_pkg::PCU_DMA_SETUP: begin
          strobe_wr_n <= ~dma_dir;
          strobe_rd_n <= dma_dir;
          dma_state   <= pcu_pkg::PCU_DMA_STROBE;
        end
        pcu_pkg::PCU_DMA_STROBE: begin
          strobe_wr_n <= 1'b1;
          strobe_rd_n <= 1'b1;
          dma_cur  <= 16'(dma_cur + `PCU_ONE);
          dma_left <= 16'(dma_left - `PCU_ONE);
          dma_state <= (dma_left == `PCU_ONE) ? pcu_pkg::PCU_DMA_IDLE
                                              : pcu_pkg::PCU_DMA_SETUP;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      dma_busy <= 1'b0;
    end else begin
      dma_busy <= (dma_state != pcu_pkg::PCU_DMA_IDLE);
    end
  end

  // ****************************************************************
  // External address bus
  // ****************************************************************
  // No enable exists: the bus is a plain output so it can never float
  // always driven
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ext_addr <= `PCU_ADDR_RST;
    end else if (dma_state != pcu_pkg::PCU_DMA_IDLE) begin
      ext_addr <= dma_cur;
    end else if (cpu_int_access) begin
      ext_addr <= cpu_int_addr;
    end
  end

  // ****************************************************************
  // Multiplexed pins
  // ****************************************************************
  assign alt_out = {strobe_rd_n, strobe_wr_n, alt_ctl_out};

  generate
    for (genvar i = 0; i < `PCU_NPINS; i++) begin : g_pin
      pcu_pin_cell u_cell (
        .clock    (clock),
        .resetn   (resetn),
        .alt_sel  (pin_sel[i]),
        .alt_out  (alt_out[i]),
        .gpio_out (gpio_out[i]),
        .gpio_oe  (gpio_oe[i]),
        .pad_out  (pad_out[i]),
        .pad_oe   (pad_oe[i])
      );
    end
  endgenerate

  // Pins are asynchronous to the core clock
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pad_meta <= `PCU_PIN_RST;
      pad_sync <= `PCU_PIN_RST;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ready_input_four <= 1'b0;
    end else begin
      ready_input_four <= (rdy_route[0] && pad_sync[`PCU_PIN_RDY_A])
                       || (rdy_route[1] && pad_sync[`PCU_PIN_RDY_B]);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  property p_attach_oe;
    $rose(usb_control_status_reg[`PCU_USB_ATTACH_EN]) |-> ##1 usb_attach_oe
      ##0 (usb_control_status_reg[`PCU_USB_ATTACH_EN] [*1] ##1 1)
      or ##1 !usb_control_status_reg[`PCU_USB_ATTACH_EN];
  endproperty
  a_attach_oe: assert property (p_attach_oe)
    else $error("attach pin not enabled after bit set");

  property p_attach_lvl;
    usb_attach_oe |-> usb_attach_out_n ==
      !$past(usb_control_status_reg[`PCU_USB_DISC]);
  endproperty
  a_attach_lvl: assert property (p_attach_lvl)
    else $error("attach pin level not inverse of bit three");

  property p_addr_hold;
    !$past(cpu_int_access) && !$past(dma_busy)
      && $past(dma_state) == pcu_pkg::PCU_DMA_IDLE |-> $stable(ext_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address bus changed without a source");

  property p_cpu_addr;
    cpu_int_access && dma_state == pcu_pkg::PCU_DMA_IDLE
      |=> ext_addr == $past(cpu_int_addr);
  endproperty
  a_cpu_addr: assert property (p_cpu_addr)
    else $error("internal address not shown on bus");

  sequence s_byte_strobe;
    dma_state == pcu_pkg::PCU_DMA_STROBE && dma_left != `PCU_ONE;
  endsequence
  sequence s_next_setup;
    dma_state == pcu_pkg::PCU_DMA_SETUP ##1
      (strobe_wr_n != strobe_rd_n);
  endsequence
  property p_dma_inc;
    s_byte_strobe |=> (dma_cur == 16'($past(dma_cur) + `PCU_ONE))
      ##0 s_next_setup ##1 ext_addr == $past(dma_cur, 2);
  endproperty
  a_dma_inc: assert property (p_dma_inc)
    else $error("DMA address did not step by one per byte");

  property p_rdy_route;
    rdy_route == 2'h3 && pad_sync[`PCU_PIN_RDY_A]
      && !pad_sync[`PCU_PIN_RDY_B] |=> ready_input_four;
  endproperty
  a_rdy_route: assert property (p_rdy_route)
    else $error("ready input four not routed from pin");

  property p_pin_default;
    pin_sel == `PCU_PIN_RST && gpio_oe == `PCU_PIN_RST
      |=> pad_oe == `PCU_PIN_RST;
  endproperty
  a_pin_default: assert property (p_pin_default)
    else $error("multiplexed pin driven while unconfigured");

  property p_addr_reset;
    !$past(resetn) |-> ext_addr == `PCU_ADDR_RST && pad_oe == `PCU_PIN_RST;
  endproperty
  a_addr_reset: assert property (p_addr_reset)
    else $error("address bus not low after reset");

endmodule // pcu_pin_ctrl

// >>> verif/pcu_board_model.sv
// Board model: pull-ups on the mux pins other than 2 and 3, and a memory latching strobes
module pcu_board_model (
  input  wire logic        clock,    // Core clock
  input  wire logic        clr,      // Clears the strobe log
  input  wire logic [7:0]  pad_out,  // Pin levels from the device
  input  wire logic [7:0]  pad_oe,   // Pin drive enables
  input  wire logic [15:0] ext_addr, // External address bus
  input  wire logic [1:0]  ext_val,  // Far-side levels on pins 2 and 3
  output logic      [7:0]  pad_in,   // Resolved pin levels
  output logic      [4:0]  n_strobe  // Strobes seen since clear
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] addr_log [0:31];
  logic [7:0]  far;
  // Pull-ups keep active-low strobes idle while pins still float
  assign far = {4'hf, ext_val, 2'b11};
  always_comb begin
    for (int i = 0; i < 8; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : far[i];
  end
  initial n_strobe = 5'h00;
  always @(posedge clock) begin
    if (clr)
      n_strobe <= 5'h00;
    else if ((pad_oe[6] && !pad_out[6]) || (pad_oe[7] && !pad_out[7])) begin
      addr_log[n_strobe] <= ext_addr;
      n_strobe           <= n_strobe + 5'h01;
    end
  end
endmodule // pcu_board_model

// >>> verif/testbench.sv
// Self-checking bench of the pin control unit
`include "pcu_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, pad_in, pad_out, pad_oe;
  logic [31:0] pwdata, prdata, rd;
  logic        cpu_int_access, usb_attach_out_n, usb_attach_oe;
  logic        ready_input_four, dma_busy, clr, err;
  logic [15:0] cpu_int_addr, ext_addr, a;
  logic [5:0]  alt_ctl_out;
  logic [1:0]  ext_val;
  logic [4:0]  n_strobe;
  logic [7:0]  g_oe, g_out;
  int          n_errors, samples_checked, seed, len;

  pcu_pin_ctrl dut (.clock(clock), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_int_access(cpu_int_access), .cpu_int_addr(cpu_int_addr),
    .alt_ctl_out(alt_ctl_out), .ext_addr(ext_addr),
    .usb_attach_out_n(usb_attach_out_n), .usb_attach_oe(usb_attach_oe),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .ready_input_four(ready_input_four), .dma_busy(dma_busy));
  pcu_board_model board (.clock(clock), .clr(clr), .pad_out(pad_out),
    .pad_oe(pad_oe), .ext_addr(ext_addr), .ext_val(ext_val),
    .pad_in(pad_in), .n_strobe(n_strobe));

  always #10 clock = ~clock;

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // An edge passes first, so back-to-back calls never reassign psel
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1'b1; paddr <= ad; pwrite <= wr; pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp,
                        input logic eerr);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp);
    chk(err, eerr);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask
  function automatic logic exp_rdy(input logic [1:0] r, input logic [1:0] p);
    return (r[0] & p[0]) | (r[1] & p[1]);
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is some 500 cycles; the limit leaves a wide margin
  initial begin
    wait_n(40000);
    n_errors++;
    stop_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'h44659a5f;
    clock = 1'b0; resetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; clr = 1'b0;
    cpu_int_access = 1'b1; cpu_int_addr = 16'h5a5a;
    alt_ctl_out = 6'h3f; ext_val = 2'b11;
    n_errors = 0; samples_checked = 0;
    wait_n(8);
    chk(ext_addr, 16'h0000);
    chk(pad_oe, 8'h00);
    chk(usb_attach_oe, 1'b0);
    resetn <= 1'b1;
    cpu_int_access <= 1'b0;
    wait_n(1);
    chk(ext_addr, 16'h0000);
    chk(pad_oe, 8'h00);
    $display("test reset done");

    for (int v = 0; v < 4; v++) begin
      apb(1'b1, `PCU_USB_CS_OFF, {28'h0, v[1:0], 2'b00});
      wait_n(2);
      chk(usb_attach_oe, v[0]);
      if (v[0]) chk(usb_attach_out_n, {31'h0, ~v[1]});
      rd_chk(`PCU_USB_CS_OFF, {28'h0, v[1:0], 2'b00}, 1'b0);
    end
    apb(1'b1, `PCU_USB_CS_OFF, 32'h4);
    wait_n(2);
    chk({usb_attach_oe, usb_attach_out_n}, 2'b11);
    apb(1'b1, `PCU_USB_CS_OFF, 32'h0);
    wait_n(2);
    chk(usb_attach_oe, 1'b0);
    rd_chk(8'h24, 32'h0, 1'b1);
    $display("test attach done");

    repeat (20) begin
      a = $random(seed);
      cpu_int_access <= 1'b1;
      cpu_int_addr   <= a;
      wait_n(2);
      chk(ext_addr, a);
    end
    cpu_int_access <= 1'b0;
    cpu_int_addr   <= ~a;
    wait_n(3);
    chk(ext_addr, a);
    $display("test cpu address done");

    apb(1'b1, `PCU_PIN_SEL_OFF, 32'hc0);
    for (int k = 0; k < 4; k++) begin
      a = $random(seed);
      len = (k == 0) ? 1 : {$random(seed)} % 16 + 1;
      clr <= 1'b1;
      apb(1'b1, `PCU_DMA_ADDR_OFF, {16'h0, a});
      clr <= 1'b0;
      apb(1'b1, `PCU_DMA_LEN_OFF, len);
      cpu_int_access <= 1'b1;
      cpu_int_addr   <= ~a;
      apb(1'b1, `PCU_DMA_CTRL_OFF, {30'h0, k[0], 1'b1});
      // Busy start is ignored; a one-byte run is already idle by then
      if (len > 1) apb(1'b1, `PCU_DMA_CTRL_OFF, {30'h0, k[0], 1'b1});
      wait_n(2);
      for (int n = 0; n < 100 && dma_busy !== 1'b0; n++) wait_n(1);
      wait_n(4);
      chk(dma_busy, 1'b0);
      chk(n_strobe, len);
      for (int i = 0; i < len; i++) chk(board.addr_log[i], 16'(a + i));
      chk(ext_addr, {16'h0, ~a});
      rd_chk(`PCU_DMA_LEN_OFF, 32'h0, 1'b0);
      rd_chk(`PCU_DMA_CTRL_OFF, {30'h0, k[0], 1'b0}, 1'b0);
    end
    cpu_int_access <= 1'b0;
    $display("test dma done");

    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `PCU_RDY_ROUTE_OFF, r);
      for (int p = 0; p < 4; p++) begin
        ext_val <= p[1:0];
        wait_n(5);
        chk(ready_input_four, exp_rdy(r[1:0], p[1:0]));
      end
    end
    $display("test routing done");

    repeat (4) begin
      g_oe = $random(seed);
      g_out = $random(seed);
      apb(1'b1, `PCU_PIN_SEL_OFF, 32'h0);
      apb(1'b1, `PCU_GPIO_OUT_OFF, {24'h0, g_out});
      apb(1'b1, `PCU_GPIO_OE_OFF, {24'h0, g_oe});
      wait_n(2);
      chk(pad_oe, g_oe);
      chk(pad_out & g_oe, g_out & g_oe);
      wait_n(3);
      rd_chk(`PCU_GPIO_IN_OFF, {24'h0, (g_out & g_oe) | ~g_oe}, 1'b0);
      alt_ctl_out <= g_out[5:0];
      apb(1'b1, `PCU_PIN_SEL_OFF, 32'h3f);
      wait_n(2);
      chk(pad_oe[5:0], 6'h3f);
      chk(pad_out[5:0], g_out[5:0]);
    end
    $display("test pin mux done");
    stop_test();
  end
endmodule // testbench
